// ===== design/sms_params.svh
/*
 * Constants of the serial module status block: buffer word addresses,
 * field positions, codes and default settings.
 * Assumes inclusion by the block's package users, once per compile unit.
 */
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
// buffer memory word addresses
`define SMS_A_STATUS   7'h04
`define SMS_A_SWECHO   7'h05
`define SMS_A_CMD      7'h0c
`define SMS_A_RXERR1   7'h10
`define SMS_A_TXERR1   7'h11
`define SMS_A_TRAIL1   7'h18
`define SMS_A_TMO1     7'h19
`define SMS_A_RXERR2   7'h50
`define SMS_A_TXERR2   7'h51
`define SMS_A_TRAIL2   7'h58
`define SMS_A_TMO2     7'h59
// status word fields
`define SMS_B_READY    15
`define SMS_B_FAULT    14
// receive error flag positions within the 4-bit flag group
`define SMS_F_BRK      3
`define SMS_F_PAR      2
`define SMS_F_FRM      1
`define SMS_F_OVR      0
// commands
`define SMS_CMD_COLD   16'h80ff
`define SMS_CMD_HOT    16'h80fe
// module status codes
`define SMS_EC_NONE    8'h00
`define SMS_EC_CPU     8'h01
`define SMS_EC_PROG    8'h02
`define SMS_EC_WORK    8'h03
`define SMS_EC_BUF     8'h04
`define SMS_EC_SWITCH  8'h05
`define SMS_EC_WDOG    8'h10
`define SMS_EC_TRAP    8'h11
`define SMS_EC_BUFTMO  8'h12
// receive and transmit codes
`define SMS_RC_TMO     8'h01
`define SMS_RC_LEN     8'h02
`define SMS_RC_OVF     8'h03
`define SMS_TC_NOTRAIL 8'h01
// defaults and limits (time-out in 0.1 s units)
`define SMS_TRAIL_DEF  8'h0d
`define SMS_TMO_DEF    16'h000a
`define SMS_TMO_MIN    16'h0001
`define SMS_TMO_MAX    16'h0258
`define SMS_MSG_MAX    896
`endif

// ===== design/sms_pkg.sv
/*
 * Types of the serial module status block.
 * Assumes sms_params.svh supplies the numeric constants.
 */
package sms_pkg;
  typedef enum logic [1:0] {
    SMS_INIT  = 2'b00,
    SMS_READY = 2'b01,
    SMS_FAULT = 2'b11
  } sms_state_t;
  // buffer memory access from the controller
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } sms_bus_t;
  // per-channel events from the serial engines (pulses, busy levels)
  typedef struct packed {
    logic rxStart;
    logic line_break_flag;
    logic par;
    logic frm;
    logic ovr;
    logic tmo;
    logic lenOver;
    logic bufOvf;
    logic txStart;
    logic noTrail;
    logic rxBusy;
    logic txBusy;
  } sms_chev_t;
  typedef struct packed {
    logic [3:0] flags;
    logic [7:0] code;
  } sms_rxerr_t;
  // whole state of the block
  typedef struct packed {
    sms_state_t            state;
    logic [7:0]            errCode;
    logic [7:0]            sw;
    logic [15:0]           cmd;
    sms_rxerr_t [1:0]      rxErr;
    logic [1:0][7:0]       txCode;
    logic [1:0][7:0]       trailStage;
    logic [1:0][7:0]       trailAct;
    logic [1:0][15:0]      tmoStage;
    logic [1:0][15:0]      tmoAct;
    logic [15:0]           rdata;
    logic [15:0]           status;
    logic                  ack;
    logic                  coldPulse;
    logic                  hotPulse;
    logic                  runLed;
    logic [1:0]            txLed;
    logic [1:0]            rxLed;
    logic [1:0]            discard;
  } sms_st_t;
endpackage : sms_pkg

// ===== design/sms_status.sv
/*
 * Status and error reporting of a two-channel serial module: status
 * word, switch echo, per-channel error words, command and settings
 * words, and the indicator outputs.
 * Assumes the serial engines report events as one-cycle pulses on mclk
 * and the controller reads and writes buffer words as one-cycle strobes.
 */
`timescale 1ns/1ps
`include "sms_params.svh"

module sms_status (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire sms_pkg::sms_bus_t  bus,
  output logic [15:0]             busRdata,
  output logic                    busAck,
  input  wire logic [3:0]         rotarySwitchOne,
  input  wire logic [3:0]         rotarySwitchTwo,
  input  wire logic               initDone,
  input  wire logic               initFault,
  input  wire logic [2:0]         initKind,
  input  wire logic               runFault,
  input  wire logic [1:0]         runKind,
  input  wire sms_pkg::sms_chev_t ch1Ev,
  input  wire sms_pkg::sms_chev_t ch2Ev,
  output logic                    coldRestart,
  output logic                    hotApplied,
  output logic [15:0]             statusWord,
  output logic [1:0]              rxDiscard,
  output logic [15:0]             trailCodes,
  output logic [31:0]             timeouts,
  output logic                    runIndicator,
  output logic                    ch1_send_indicator,
  output logic                    ch1_receive_indicator,
  output logic                    ch2_send_indicator,
  output logic                    ch2_receive_indicator
);
  sms_pkg::sms_st_t  s;
  sms_pkg::sms_st_t  next_s;
  sms_pkg::sms_chev_t [1:0] ev;

  assign ev = {ch2Ev, ch1Ev};

  // next state of the whole block
  always_comb begin
    next_s = s;
    next_s.ack = bus.rd | bus.wr;
    next_s.coldPulse = 1'b0;
    next_s.hotPulse = 1'b0;
    next_s.discard = 2'b00;
    next_s.sw = {rotarySwitchOne, rotarySwitchTwo};
    // module state and status code
    case (s.state)
      sms_pkg::SMS_INIT: begin
        if (initFault) begin
          next_s.state = sms_pkg::SMS_FAULT;
          case (initKind)
            3'h1: next_s.errCode = `SMS_EC_CPU;
            3'h2: next_s.errCode = `SMS_EC_PROG;
            3'h3: next_s.errCode = `SMS_EC_WORK;
            3'h4: next_s.errCode = `SMS_EC_BUF;
            default: next_s.errCode = `SMS_EC_SWITCH;
          endcase
        end else if (initDone) begin
          next_s.state = sms_pkg::SMS_READY;
          next_s.errCode = `SMS_EC_NONE;
        end
      end
      sms_pkg::SMS_READY: begin
        if (runFault) begin
          next_s.state = sms_pkg::SMS_FAULT;
          case (runKind)
            2'h0: next_s.errCode = `SMS_EC_WDOG;
            2'h1: next_s.errCode = `SMS_EC_TRAP;
            default: next_s.errCode = `SMS_EC_BUFTMO;
          endcase
        end
      end
      sms_pkg::SMS_FAULT: next_s.state = sms_pkg::SMS_FAULT;
      default: next_s.state = sms_pkg::SMS_INIT;
    endcase
    // cold reset completes when initialisation ends; hot at once
    if (s.cmd == `SMS_CMD_COLD && s.state != sms_pkg::SMS_INIT) begin
      next_s.cmd = 16'h0000;
    end
    if (s.cmd == `SMS_CMD_HOT) begin
      next_s.cmd = 16'h0000;
      next_s.hotPulse = 1'b1;
      for (int i = 0; i < 2; i++) begin
        next_s.trailAct[i] = s.trailStage[i];
        if (s.tmoStage[i] >= `SMS_TMO_MIN &&
            s.tmoStage[i] <= `SMS_TMO_MAX) begin
          next_s.tmoAct[i] = s.tmoStage[i];
        end
      end
    end
    // channel error words and indicators
    for (int i = 0; i < 2; i++) begin
      if (ev[i].rxStart) begin
        next_s.rxErr[i] = '0; // new message starts clean
      end
      if (ev[i].txStart) begin
        next_s.txCode[i] = `SMS_EC_NONE;
      end
      if (ev[i].line_break_flag) next_s.rxErr[i].flags[`SMS_F_BRK] = 1'b1;
      if (ev[i].par) next_s.rxErr[i].flags[`SMS_F_PAR] = 1'b1;
      if (ev[i].frm) next_s.rxErr[i].flags[`SMS_F_FRM] = 1'b1;
      if (ev[i].ovr) next_s.rxErr[i].flags[`SMS_F_OVR] = 1'b1;
      if (ev[i].bufOvf) begin
        next_s.rxErr[i].code = `SMS_RC_OVF;
      end else if (ev[i].lenOver) begin
        next_s.rxErr[i].code = `SMS_RC_LEN;
      end else if (ev[i].tmo) begin
        next_s.rxErr[i].code = `SMS_RC_TMO;
      end
      next_s.discard[i] = ev[i].line_break_flag | ev[i].par | ev[i].frm |
                          ev[i].ovr | ev[i].lenOver | ev[i].bufOvf;
      if (ev[i].noTrail) begin
        next_s.txCode[i] = `SMS_TC_NOTRAIL;
      end
      next_s.txLed[i] = ev[i].txBusy;
      next_s.rxLed[i] = ev[i].rxBusy;
    end
    // controller writes: only command and settings words take data
    if (bus.wr) begin
      case (bus.addr)
        `SMS_A_CMD:    next_s.cmd = bus.wdata;
        `SMS_A_TRAIL1: next_s.trailStage[0] = bus.wdata[7:0];
        `SMS_A_TRAIL2: next_s.trailStage[1] = bus.wdata[7:0];
        `SMS_A_TMO1:   next_s.tmoStage[0] = bus.wdata;
        `SMS_A_TMO2:   next_s.tmoStage[1] = bus.wdata;
        default: ;
      endcase
    end
    // cold reset restarts everything with default settings
    if (bus.wr && bus.addr == `SMS_A_CMD &&
        bus.wdata == `SMS_CMD_COLD) begin
      next_s.state = sms_pkg::SMS_INIT;
      next_s.errCode = `SMS_EC_NONE;
      next_s.coldPulse = 1'b1;
      next_s.rxErr = '0;
      next_s.txCode = '0;
      for (int i = 0; i < 2; i++) begin
        next_s.trailStage[i] = `SMS_TRAIL_DEF;
        next_s.trailAct[i] = `SMS_TRAIL_DEF;
        next_s.tmoStage[i] = `SMS_TMO_DEF;
        next_s.tmoAct[i] = `SMS_TMO_DEF;
      end
    end
    next_s.runLed = (next_s.state == sms_pkg::SMS_READY);
    // status word copy kept in a flop for the output
    next_s.status = {next_s.state == sms_pkg::SMS_READY,
                     next_s.state == sms_pkg::SMS_FAULT,
                     6'h00, next_s.errCode};
    // read data, unmapped words read zero
    next_s.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        `SMS_A_STATUS: next_s.rdata = {s.state == sms_pkg::SMS_READY,
                                       s.state == sms_pkg::SMS_FAULT,
                                       6'h00, s.errCode};
        `SMS_A_SWECHO: next_s.rdata = {8'h00, s.sw};
        `SMS_A_CMD:    next_s.rdata = s.cmd;
        `SMS_A_RXERR1: next_s.rdata = {4'h0, s.rxErr[0]};
        `SMS_A_RXERR2: next_s.rdata = {4'h0, s.rxErr[1]};
        `SMS_A_TXERR1: next_s.rdata = {8'h00, s.txCode[0]};
        `SMS_A_TXERR2: next_s.rdata = {8'h00, s.txCode[1]};
        `SMS_A_TRAIL1: next_s.rdata = {8'h00, s.trailStage[0]};
        `SMS_A_TRAIL2: next_s.rdata = {8'h00, s.trailStage[1]};
        `SMS_A_TMO1:   next_s.rdata = s.tmoStage[0];
        `SMS_A_TMO2:   next_s.rdata = s.tmoStage[1];
        default:       next_s.rdata = 16'h0000;
      endcase
    end
  end

  // state register with synchronous reset (acts as a cold start)
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.state <= sms_pkg::SMS_INIT;
      s.trailStage <= {2{`SMS_TRAIL_DEF}};
      s.trailAct <= {2{`SMS_TRAIL_DEF}};
      s.tmoStage <= {2{`SMS_TMO_DEF}};
      s.tmoAct <= {2{`SMS_TMO_DEF}};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign busRdata = s.rdata;
  assign busAck = s.ack;
  assign coldRestart = s.coldPulse;
  assign hotApplied = s.hotPulse;
  assign statusWord = s.status;
  assign rxDiscard = s.discard;
  assign trailCodes = {s.trailAct[1], s.trailAct[0]};
  assign timeouts = {s.tmoAct[1], s.tmoAct[0]};
  assign runIndicator = s.runLed;
  assign ch1_send_indicator = s.txLed[0];
  assign ch1_receive_indicator = s.rxLed[0];
  assign ch2_send_indicator = s.txLed[1];
  assign ch2_receive_indicator = s.rxLed[1];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_status_read;
    bus.rd && bus.addr == `SMS_A_STATUS |=>
      busRdata[13:8] == 6'h00 && busRdata[7:0] == $past(s.errCode);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word layout wrong");
  property p_run_led;
    runIndicator == (s.state == sms_pkg::SMS_READY);
  endproperty
  a_run_led: assert property (p_run_led)
    else $error("run indicator disagrees with ready");
  property p_no_code;
    s.state != sms_pkg::SMS_FAULT |-> s.errCode == `SMS_EC_NONE;
  endproperty
  a_no_code: assert property (p_no_code)
    else $error("error code set without fault");
  property p_init_fault;
    s.state == sms_pkg::SMS_INIT && initFault && !bus.wr |=>
      s.state == sms_pkg::SMS_FAULT && s.errCode >= `SMS_EC_CPU &&
      s.errCode <= `SMS_EC_SWITCH;
  endproperty
  a_init_fault: assert property (p_init_fault)
    else $error("init fault not reported");
  property p_run_fault;
    s.state == sms_pkg::SMS_READY && runFault && !bus.wr |=>
      statusWord[15:14] == 2'b01 && statusWord[7:4] == 4'h1;
  endproperty
  a_run_fault: assert property (p_run_fault)
    else $error("run fault not reported");
  property p_break;
    ch1Ev.line_break_flag && !bus.wr |=> s.rxErr[0].flags[`SMS_F_BRK] && rxDiscard[0];
  endproperty
  a_break: assert property (p_break)
    else $error("break not flagged");
  property p_timeout;
    ch2Ev.tmo && !ch2Ev.lenOver && !ch2Ev.bufOvf && !ch2Ev.line_break_flag &&
      !ch2Ev.par && !ch2Ev.frm && !ch2Ev.ovr && !bus.wr |=>
      s.rxErr[1].code == `SMS_RC_TMO && !rxDiscard[1];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out misreported");
  property p_hot_done;
    bus.wr && bus.addr == `SMS_A_CMD && bus.wdata == `SMS_CMD_HOT |=>
      ##1 s.cmd == 16'h0000 && hotApplied;
  endproperty
  a_hot_done: assert property (p_hot_done)
    else $error("hot reset not completed");
  property p_echo;
    bus.rd && bus.addr == `SMS_A_SWECHO && !$past(rst) |=>
      busRdata == {8'h00, $past({rotarySwitchOne, rotarySwitchTwo}, 2)};
  endproperty
  a_echo: assert property (p_echo)
    else $error("switch echo wrong");
  property p_rx_layout;
    bus.rd && (bus.addr == `SMS_A_RXERR1 || bus.addr == `SMS_A_RXERR2) |=>
      busRdata[15:12] == 4'h0;
  endproperty
  a_rx_layout: assert property (p_rx_layout)
    else $error("receive error word upper bits set");
  property p_tx_layout;
    bus.rd && (bus.addr == `SMS_A_TXERR1 || bus.addr == `SMS_A_TXERR2) |=>
      busRdata[15:8] == 8'h00;
  endproperty
  a_tx_layout: assert property (p_tx_layout)
    else $error("transmit error word upper bits set");
  property p_no_trail;
    ch2Ev.noTrail && !bus.wr |=> s.txCode[1] == `SMS_TC_NOTRAIL;
  endproperty
  a_no_trail: assert property (p_no_trail)
    else $error("missing trailing code not reported");
  property p_activity;
    1'b1 |=> ch1_send_indicator == $past(ch1Ev.txBusy) &&
      ch2_receive_indicator == $past(ch2Ev.rxBusy);
  endproperty
  a_activity: assert property (p_activity)
    else $error("activity indicator wrong");
  property p_ro_tx;
    bus.wr && bus.addr == `SMS_A_TXERR1 && !ch1Ev.txStart &&
      !ch1Ev.noTrail |=> $stable(s.txCode[0]);
  endproperty
  a_ro_tx: assert property (p_ro_tx)
    else $error("write disturbed transmit error word");
  property p_cold;
    bus.wr && bus.addr == `SMS_A_CMD && bus.wdata == `SMS_CMD_COLD |=>
      coldRestart && statusWord == 16'h0000 &&
      trailCodes == {2{`SMS_TRAIL_DEF}};
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold reset not applied");
  c_ready: cover property (s.state == sms_pkg::SMS_INIT ##1
                           s.state == sms_pkg::SMS_READY);
  c_fault: cover property (s.state == sms_pkg::SMS_FAULT);
  c_discard: cover property (rxDiscard != 2'b00);
endmodule : sms_status

// ===== tb/sms_host_model.sv
/*
 * Controller model: issues single buffer word reads and writes.
 * Assumes one-cycle strobes, a registered acknowledge one cycle later.
 */
`timescale 1ns/1ps
module sms_host_model (
  input  wire logic        mclk,
  output sms_pkg::sms_bus_t bus,
  input  wire logic [15:0] busRdata,
  input  wire logic        busAck
);
  // bus idle until the first request
  initial begin
    bus = '0;
  end

  // one access: strobe for one cycle, ack and data taken a cycle later
  task automatic access(input logic isWr, input logic [6:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ok);
    @(negedge mclk);
    bus.rd    = !isWr;
    bus.wr    = isWr;
    bus.addr  = a;
    bus.wdata = d;
    @(negedge mclk);
    ok        = (busAck === 1'h1);
    q         = ok ? busRdata : 16'h0000;
    bus       = '0;
  endtask : access
endmodule : sms_host_model

// ===== tb/tb_serial_module_status_reporting.sv
/*
 * Self-checking bench of the status block: words read and written
 * through the controller model, events and faults driven directly.
 * Assumes sms_params.svh and sms_pkg are compiled first.
 */
`timescale 1ns/1ps
module tb_serial_module_status_reporting;
  logic               mclk, rst, busAck, initDone, initFault, runFault;
  logic               runIndicator, coldRestart, hotApplied;
  sms_pkg::sms_bus_t  bus;
  logic [15:0]        busRdata, statusWord, trailCodes;
  logic [31:0]        timeouts;
  logic [3:0]         swOne, swTwo, leds;
  logic [2:0]         initKind;
  logic [1:0]         runKind, rxDiscard;
  sms_pkg::sms_chev_t chEv [2];
  int                 miscompares, comparisons, cycles;
  int                 kIdx [8] = '{10, 9, 8, 7, 6, 5, 4, 2};
  logic [15:0]        expW [8] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100,
                                   16'h0001, 16'h0002, 16'h0003, 16'h0001};
  logic [7:0]         disc = 8'h6f;

  sms_status u_dut (.mclk(mclk), .rst(rst), .bus(bus),
    .busRdata(busRdata), .busAck(busAck), .rotarySwitchOne(swOne),
    .rotarySwitchTwo(swTwo), .initDone(initDone), .initFault(initFault),
    .initKind(initKind), .runFault(runFault), .runKind(runKind),
    .ch1Ev(chEv[0]), .ch2Ev(chEv[1]), .coldRestart(coldRestart),
    .hotApplied(hotApplied), .statusWord(statusWord),
    .rxDiscard(rxDiscard),
    .trailCodes(trailCodes), .timeouts(timeouts),
    .runIndicator(runIndicator), .ch1_send_indicator(leds[0]),
    .ch1_receive_indicator(leds[1]), .ch2_send_indicator(leds[2]),
    .ch2_receive_indicator(leds[3]));

  sms_host_model u_host (.mclk(mclk), .bus(bus), .busRdata(busRdata),
    .busAck(busAck));

  // 100 MHz clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rdChk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic        ok;
    u_host.access(1'h0, a, 16'h0000, q, ok);
    check("ack", 1'h1, ok);
    check($sformatf("word %h", a), exp, q);
  endtask : rdChk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        ok;
    u_host.access(1'h1, a, d, q, ok);
    check("ack", 1'h1, ok);
  endtask : wr

  // one-cycle pulse of a channel event, selected by bit index
  task automatic evt(input int ch, input int k);
    @(negedge mclk);
    chEv[ch] = sms_pkg::sms_chev_t'(12'h001 << k);
    @(negedge mclk);
    chEv[ch] = '0;
  endtask : evt

  // one-cycle pulse of {runFault, initFault, initDone}
  task automatic ctl(input logic [2:0] sel, input logic [2:0] kind);
    @(negedge mclk);
    {runFault, initFault, initDone} = sel;
    initKind = kind;
    runKind  = kind[1:0];
    @(negedge mclk);
    {runFault, initFault, initDone} = 3'h0;
  endtask : ctl

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    rst = 1'h1;
    {runFault, initFault, initDone} = 3'h0;
    initKind = 3'h0;
    runKind = 2'h0;
    swOne = 4'ha;
    swTwo = 4'h5;
    chEv[0] = '0;
    chEv[1] = '0;
    repeat (20) @(negedge mclk);
    rst = 1'h0;
    rdChk(7'h04, 16'h0000);
    check("run", 1'h0, runIndicator);
    check("trail", 16'h0d0d, trailCodes);
    check("tmo", 32'h000a_000a, timeouts);
    rdChk(7'h05, 16'h00a5);
    wr(7'h05, 16'hffff);
    rdChk(7'h05, 16'h00a5);
    ctl(3'h1, 3'h0);
    rdChk(7'h04, 16'h8000);
    check("status", 16'h8000, statusWord);
    check("run", 1'h1, runIndicator);
    // every receive and transmit error kind on both channels
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        evt(c, i < 7 ? 11 : 3);
        evt(c, kIdx[i]);
        check("discard", disc[i], rxDiscard[c]);
        rdChk((c ? 7'h50 : 7'h10) + 7'(i == 7), expW[i]);
      end
      wr(c ? 7'h51 : 7'h11, 16'h0000);
      rdChk(c ? 7'h51 : 7'h11, 16'h0001);
      evt(c, 11);
      rdChk(c ? 7'h50 : 7'h10, 16'h0000);
      chEv[c].rxBusy = 1'h1;
      chEv[c].txBusy = 1'h1;
      repeat (2) @(negedge mclk);
      check("leds", c ? 4'hc : 4'h3, leds);
      chEv[c] = '0;
      repeat (2) @(negedge mclk);
      check("leds", 4'h0, leds);
    end
    // staged settings apply at hot reset; out-of-range time-out refused
    wr(7'h18, 16'h0003);
    wr(7'h19, 16'h0032);
    wr(7'h59, 16'h0259);
    wr(7'h0c, 16'h80fe);
    @(negedge mclk);
    check("hot", 1'h1, hotApplied);
    repeat (2) @(negedge mclk);
    rdChk(7'h0c, 16'h0000);
    check("trail", 16'h0d03, trailCodes);
    check("tmo", 32'h000a_0032, timeouts);
    // run faults, cold recovery, init faults, cold recovery
    for (int j = 0; j < 5; j++) begin
      ctl(3'h4, 3'(j % 3));
      rdChk(7'h04, 16'h4010 + 16'(j % 3));
      check("run", 1'h0, runIndicator);
      wr(7'h0c, 16'h80ff);
      check("cold", 1'h1, coldRestart);
      rdChk(7'h04, 16'h0000);
      ctl(3'h2, 3'(j + 1));
      rdChk(7'h04, 16'h4000 + 16'(j + 1));
      ctl(3'h1, 3'h0);
      rdChk(7'h04, 16'h4000 + 16'(j + 1));
      wr(7'h0c, 16'h80ff);
      ctl(3'h1, 3'h0);
      rdChk(7'h04, 16'h8000);
      rdChk(7'h0c, 16'h0000);
      check("trail", 16'h0d0d, trailCodes);
    end
    results();
  end
endmodule : tb_serial_module_status_reporting
